/* cvr_cfg.svh */
`ifndef CVR_CFG_SVH
`define CVR_CFG_SVH
// register indices as printed; byte address is four times the index
`define CVR_IDX_CMP_CTRL 8'h9C
`define CVR_IDX_LADDER_CTRL 8'h9D
`define CVR_ADDR_W 12
`define CVR_CMP_CTRL_RST 8'h07
`define CVR_LADDER_CTRL_RST 8'h00
`define CVR_LADDER_WMASK 8'hEF
`define CVR_BIT_POWER_ON 7
`define CVR_BIT_PIN_DRIVE 6
`define CVR_BIT_RANGE_WIDE 5
`define CVR_BIT_UNUSED 4
`define CVR_CMP_WMASK 8'h3F
`define CVR_MODE_INTERNAL_REF 3'b110
`define CVR_MODE_OFF 3'b111
`define CVR_NARROW_BASE 6'h08
`define CVR_OKAY 2'b00
`define CVR_SLVERR 2'b10
`endif

/* cvr_pkg.sv */
package cvr_pkg;
    typedef logic [7:0] cvr_reg_t;
    typedef logic [3:0] cvr_tap_t;
    typedef logic [2:0] cvr_mode_t;
    typedef logic [6:0] cvr_level_t;
endpackage

/* cvr_regs.sv */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cvr_cfg.svh"
module cvr_regs (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`CVR_ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`CVR_ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // comparator results from the analog side
    input wire logic i_cmp_a_raw,
    input wire logic i_cmp_b_raw,
    // ladder controls
    output logic o_ladder_power_on,
    output logic o_ladder_pin_drive,
    output logic o_ladder_range_wide,
    output cvr_pkg::cvr_tap_t o_ladder_tap_select,
    // ladder level in 1/96ths of supply
    output cvr_pkg::cvr_level_t o_ladder_output_level,
    // comparator controls
    output cvr_pkg::cvr_mode_t o_cmp_mode_select,
    output logic o_cmp_input_swap,
    output logic o_cmp_a_invert,
    output logic o_cmp_b_invert,
    output logic o_cmp_ref_to_vinp
);
    import cvr_pkg::*;

    cvr_reg_t ladder_q;
    cvr_reg_t cmp_q;
    logic [1:0] cmp_s1_q;
    logic [1:0] cmp_s2_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [`CVR_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic aw_ok;
    logic w_ok;
    logic do_write;
    logic [`CVR_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [1:0] cmp_res;

    // index decode: aligned word at four times the printed index
    function automatic logic is_reg(input logic [`CVR_ADDR_W-1:0] a,
                                    input logic [7:0] idx);
        is_reg = (a[1:0] == 2'b00) && (a[`CVR_ADDR_W-1:2] == {2'b00, idx});
    endfunction

    function automatic logic is_mapped(input logic [`CVR_ADDR_W-1:0] a);
        is_mapped = is_reg(a, `CVR_IDX_CMP_CTRL) ||
                    is_reg(a, `CVR_IDX_LADDER_CTRL);
    endfunction

    // write channels accepted independently, in either order
    assign o_awready = !aw_hold_q && !bvalid_q;
    assign o_wready = !w_hold_q && !bvalid_q;
    assign aw_ok = aw_hold_q || (i_awvalid && o_awready);
    assign w_ok = w_hold_q || (i_wvalid && o_wready);
    assign do_write = aw_ok && w_ok && !bvalid_q;
    assign wr_addr = aw_hold_q ? awaddr_q : i_awaddr;
    assign wr_data = w_hold_q ? wdata_q : i_wdata;
    assign wr_strb = w_hold_q ? wstrb_q : i_wstrb;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= i_awaddr;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CVR_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_addr) ? `CVR_OKAY : `CVR_SLVERR;
        end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ladder control; bit 4 never stored
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ladder_q <= `CVR_LADDER_CTRL_RST;
        end else if (do_write && wr_strb[0] &&
                     is_reg(wr_addr, `CVR_IDX_LADDER_CTRL)) begin
            ladder_q <= wr_data[7:0] & `CVR_LADDER_WMASK;
        end
    end

    // comparator control; result bits are never stored from the bus
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_q <= `CVR_CMP_CTRL_RST;
        end else if (do_write && wr_strb[0] &&
                     is_reg(wr_addr, `CVR_IDX_CMP_CTRL)) begin
            cmp_q <= wr_data[7:0] & `CVR_CMP_WMASK;
        end
    end

    // comparator outputs come from the analog side, so synchronise
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_s1_q <= 2'b00;
            cmp_s2_q <= 2'b00;
        end else begin
            cmp_s1_q <= {i_cmp_b_raw, i_cmp_a_raw};
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // result bits read as zero while comparators are off
    assign cmp_res = (cmp_q[2:0] == `CVR_MODE_OFF) ? 2'b00 :
                     (cmp_s2_q ^ {cmp_q[5], cmp_q[4]});

    // read channel
    assign o_arready = !rvalid_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `CVR_OKAY;
        end else if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(i_araddr) ? `CVR_OKAY : `CVR_SLVERR;
            if (is_reg(i_araddr, `CVR_IDX_LADDER_CTRL)) begin
                rdata_q <= {24'h00_0000, ladder_q};
            end else if (is_reg(i_araddr, `CVR_IDX_CMP_CTRL)) begin
                rdata_q <= {24'h00_0000, cmp_res, cmp_q[5:0]};
            end else begin
                rdata_q <= '0;
            end
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ladder level in 1/96ths: wide 4*tap, narrow 24+3*tap
    function automatic cvr_level_t ladder_level(input logic wide,
                                                input cvr_tap_t tap);
        if (wide) begin
            ladder_level = {1'b0, tap, 2'b00};
        end else begin
            // narrow top is 69/96, so the level needs seven bits
            ladder_level = ({1'b0, `CVR_NARROW_BASE} * 7'h03) +
                           ({3'b000, tap} * 7'h03);
        end
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ladder_output_level <= '0;
        end else if (ladder_q[`CVR_BIT_POWER_ON]) begin
            o_ladder_output_level <= ladder_level(
                ladder_q[`CVR_BIT_RANGE_WIDE], ladder_q[3:0]);
        end else begin
            o_ladder_output_level <= '0;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_ladder_power_on = ladder_q[`CVR_BIT_POWER_ON];
    assign o_ladder_pin_drive = ladder_q[`CVR_BIT_PIN_DRIVE];
    assign o_ladder_range_wide = ladder_q[`CVR_BIT_RANGE_WIDE];
    assign o_ladder_tap_select = ladder_q[3:0];
    assign o_cmp_mode_select = cmp_q[2:0];
    assign o_cmp_input_swap = cmp_q[3];
    assign o_cmp_a_invert = cmp_q[4];
    assign o_cmp_b_invert = cmp_q[5];
    assign o_cmp_ref_to_vinp =
        (cmp_q[2:0] == `CVR_MODE_INTERNAL_REF);
endmodule

/* cvr_regs_props.sv */
`timescale 1ns/1ps
`include "cvr_cfg.svh"
module cvr_regs_props (
    // clock, reset and bus
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [`CVR_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    // ladder and comparator
    input wire logic o_ladder_power_on,
    input wire logic o_ladder_pin_drive,
    input wire logic o_ladder_range_wide,
    input wire cvr_pkg::cvr_tap_t o_ladder_tap_select,
    input wire cvr_pkg::cvr_level_t o_ladder_output_level,
    input wire cvr_pkg::cvr_mode_t o_cmp_mode_select,
    input wire logic o_cmp_ref_to_vinp
);
    import cvr_pkg::*;
    logic wr_go;
    logic [31:0] lad;
    assign wr_go = i_awvalid && o_awready && i_wvalid && o_wready &&
        i_wstrb[0] && i_awaddr == 12'h274;
    assign lad = {24'h00_0000, o_ladder_power_on, o_ladder_pin_drive,
        o_ladder_range_wide, 1'b0, o_ladder_tap_select};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    AST_REF_MODE: assert property (
        o_cmp_ref_to_vinp == (o_cmp_mode_select == 3'b110))
        else $error("ref routing wrong");
    AST_LVL_OFF: assert property (
        !o_ladder_power_on |=> o_ladder_output_level == 7'h00)
        else $error("level while off");
    AST_LVL_WIDE: assert property (
        o_ladder_power_on && o_ladder_range_wide |=>
        o_ladder_output_level == {1'b0, $past(o_ladder_tap_select), 2'b00})
        else $error("wide level wrong");
    AST_LVL_NARROW: assert property (
        o_ladder_power_on && !o_ladder_range_wide |=>
        o_ladder_output_level ==
        7'h18 + 7'($past(o_ladder_tap_select)) * 7'h03)
        else $error("narrow level wrong");
    AST_WR_EFFECT: assert property (
        wr_go |=> lad == ($past(i_wdata) & 32'h0000_00ef))
        else $error("write lost");
    AST_WR_RESP: assert property (
        wr_go |=> o_bvalid && o_bresp == 2'b00)
        else $error("no okay response");
    AST_B_DONE: assert property (
        o_bvalid && i_bready |=> !o_bvalid)
        else $error("response not retired");
    AST_B_REFUSE: assert property (
        o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while answering");
    AST_RD_HI: assert property (
        o_rvalid |-> o_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
endmodule
bind cvr_regs cvr_regs_props u_props (.*);

/* tb.sv */
`timescale 1ns/1ps
`include "cvr_cfg.svh"
module tb;
    import cvr_pkg::*;
    logic i_sys_clk, i_rst_b, i_awvalid, o_awready, i_wvalid, o_wready;
    logic o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
    logic [11:0] i_awaddr, i_araddr;
    logic [2:0] i_awprot, i_arprot;
    logic [31:0] i_wdata, o_rdata, q;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, r;
    logic i_cmp_a_raw, i_cmp_b_raw, o_ladder_power_on, o_ladder_pin_drive;
    logic o_ladder_range_wide, o_cmp_input_swap, o_cmp_a_invert;
    logic o_cmp_b_invert, o_cmp_ref_to_vinp;
    cvr_tap_t o_ladder_tap_select;
    cvr_level_t o_ladder_output_level;
    cvr_mode_t o_cmp_mode_select;
    int failures = 0;
    int compares = 0;
    logic [7:0] lad;
    logic [5:0] cmpf;
    // address, data, read back, level
    logic [34:0] rows [7] = '{{12'h274, 8'hff, 8'hef, 7'h3c},
        {12'h274, 8'h80, 8'h80, 7'h18}, {12'h274, 8'h8f, 8'h8f, 7'h45},
        {12'h274, 8'ha1, 8'ha1, 7'h04}, {12'h274, 8'h60, 8'h60, 7'h00},
        {12'h270, 8'hfe, 8'hfe, 7'h00}, {12'h270, 8'h07, 8'h07, 7'h00}};
    cvr_regs dut (.*);
    assign lad = {o_ladder_power_on, o_ladder_pin_drive, o_ladder_range_wide,
        1'b0, o_ladder_tap_select};
    assign cmpf = {o_cmp_b_invert, o_cmp_a_invert, o_cmp_input_swap,
        o_cmp_mode_select};
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // outputs sampled at the falling edge, where they have settled
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
        input logic [3:0] s);
        logic ah, wh, bh;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_bready <= 1'b1;
        i_wdata <= {24'h00_0000, d};
        i_wstrb <= s;
        do begin
            @(negedge i_sys_clk);
            ah = i_awvalid && o_awready;
            wh = i_wvalid && o_wready;
            bh = o_bvalid;
            r = o_bresp;
            @(posedge i_sys_clk);
            if (ah) i_awvalid <= 1'b0;
            if (wh) i_wvalid <= 1'b0;
        end while (!bh);
        i_bready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [11:0] a);
        logic h, g;
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        do begin
            @(negedge i_sys_clk);
            h = i_arvalid && o_arready;
            g = o_rvalid;
            q = o_rdata;
            r = o_rresp;
            @(posedge i_sys_clk);
            if (h) i_arvalid <= 1'b0;
        end while (!g);
        i_rready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #50000 failures++;
        tally_and_finish;
    end
    initial begin
        {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_awaddr, i_araddr, i_awprot, i_arprot, i_wdata, i_wstrb} = '0;
        {i_cmp_a_raw, i_cmp_b_raw} = '0;
        repeat (8) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        chk(32'({lad, 2'b00, cmpf}), 32'h0000_0007);
        foreach (rows[k]) begin
            wr(rows[k][34:23], rows[k][22:15], 4'h1);
            chk(32'(r), 32'h0);
            rd(rows[k][34:23]);
            chk(q, 32'(rows[k][14:7]));
            chk(32'(o_ladder_output_level), 32'(rows[k][6:0]));
            if (rows[k][34:23] == 12'h274) begin
                chk(32'(lad), 32'(rows[k][14:7]));
            end else begin
                chk(32'(cmpf), 32'(rows[k][12:7]));
            end
        end
        wr(12'h274, 8'h9f, 4'h0);
        rd(12'h274);
        chk(q, 32'h0000_0060);
        wr(12'h300, 8'h01, 4'h1);
        chk(32'(r), 32'h2);
        wr(12'h275, 8'h01, 4'h1);
        chk(32'(r), 32'h2);
        rd(12'h300);
        chk({q[29:0], r}, 32'h2);
        wr(12'h270, 8'h26, 4'h1);
        i_cmp_a_raw <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        rd(12'h270);
        chk(q, 32'h0000_00e6);
        chk(32'(o_cmp_ref_to_vinp), 32'h1);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        rd(12'h270);
        chk(q, 32'h0000_0007);
        rd(12'h274);
        chk(q, 32'h0000_0000);
        tally_and_finish;
    end
endmodule
